// ===== hdl/res_pkg.sv
/*
 * Shared constants and carriers of the retirement event selector.
 * Assumes a single core clock and a plain register port.
 */
`default_nettype none
package res_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_GRP_CTL0  = 8'h00;
   localparam logic [7:0] OFS_CNT_CFG0  = 8'h10;
   localparam logic [7:0] OFS_STATUS    = 8'h28;
   localparam int         NUM_GRP       = 4;
   localparam int         NUM_CNT       = 6;
   // Event select control layout
   localparam int         ESEL_HI       = 31;
   localparam int         ESEL_LO       = 25;
   localparam int         EMASK_HI      = 24;
   localparam int         EMASK_LO      = 9;
   // Counter config layout
   localparam int         SRC_HI        = 15;
   localparam int         SRC_LO        = 13;
   localparam int         CFG_EN_BIT    = 12;
   localparam int         CFG_PSAMP_BIT = 1;
   localparam int         CFG_GHI_BIT   = 0;
   localparam logic [31:0] CFG_WMASK    = 32'h0000_f003;
   localparam logic [31:0] RST_VAL      = 32'h0000_0000;
   localparam int         STAT_INC_LO   = 8;
   // Event codes
   localparam logic [6:0] ESEL_MISPRED  = 7'h03;
   localparam logic [6:0] ESEL_ASSIST   = 7'h03;
   localparam logic [6:0] ESEL_CLEAR    = 7'h02;
   localparam logic [2:0] SRC_MISPRED   = 3'h4;
   localparam logic [2:0] SRC_GRP23     = 3'h5;
   // Mask bit positions
   localparam int         NON_SPECULATIVE_QUAL        = 0;
   localparam int         FP_STACK_UNDERFLOW_SEL      = 0;
   localparam int         FP_STACK_OVERFLOW_SEL       = 1;
   localparam int         RESULT_OVERFLOW_ASSIST_SEL  = 2;
   localparam int         RESULT_UNDERFLOW_ASSIST_SEL = 3;
   localparam int         INPUT_OPERAND_ASSIST_SEL    = 4;
   localparam int         CLEAR_ANY_SEL               = 0;
   localparam int         MEM_ORDER_FLUSH_SEL         = 2;
   localparam int         SELF_MOD_CODE_FLUSH_SEL     = 6;
   localparam int         ASSIST_TYPES  = 5;
   // Share of clear cycles counted: one in this many
   localparam int         CLEAR_DIV     = 2;

   typedef struct packed {
      logic       mispred_retire;
      logic       bogus;
      logic       fp_assist_retire_evt;
      logic [4:0] assist_type;
      logic       clr_active;
      logic       clr_mem_order;
      logic       clr_self_mod;
   } res_retire_s;
endpackage
`default_nettype wire

// ===== hdl/res_selector.sv
/*
 * Retirement event selector: qualifies three at-retirement events
 * onto six counter increment pulses (counters 12..17).
 * Assumes retirement signals arrive on ref_clk from core logic.
 */
// Functional notes
// - Select 03h with source 04h counts retired mispredicted branches.
// - Mask bit 0 limits mispredicted branch counting to non-speculative retirements.
// - Mispredicted branches come from groups 0 (12,13,16) and 1 (14,15,17).
// - Select 03h source 05h counts assisted x87 retirements, groups 2 and 3.
// - Mask bit 0 stack underflow assists, bit 1 stack overflow assists.
// - Mask bit 2 result overflow assists, bit 3 result underflow assists.
// - Mask bit 4 selects input operand assists.
// - Select 02h source 05h counts pipeline clears, groups 2 and 3.
// - Mask bit 0 counts a portion of clearing cycles, any cause.
// - Mask bit 2 counts each memory ordering clear once.
// - Mask bit 6 counts each self-modifying code clear once.
`timescale 1ns/1ps
`default_nettype none
module res_selector (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   // Register port
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   // Retirement events
   input  wire res_pkg::res_retire_s retire_in,
   // Counter side
   output logic      [5:0]           cnt_inc,
   output logic                      precise_sampling_req
);
   logic [31:0] grp_ctl_r [res_pkg::NUM_GRP];
   logic [31:0] cnt_cfg_r [res_pkg::NUM_CNT];
   logic [31:0] reg_rdata_r;
   logic [5:0]  cnt_inc_r;
   logic [5:0]  cfg_valid;
   logic [5:0]  hit;
   logic [$clog2(res_pkg::CLEAR_DIV)-1:0] clr_div_r;
   logic        clr_phase;

   // Register writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int g = 0; g < res_pkg::NUM_GRP; g++) begin
            grp_ctl_r[g] <= res_pkg::RST_VAL;
         end
         for (int c = 0; c < res_pkg::NUM_CNT; c++) begin
            cnt_cfg_r[c] <= res_pkg::RST_VAL;
         end
      end else if (reg_wr) begin
         for (int g = 0; g < res_pkg::NUM_GRP; g++) begin
            if (reg_addr == res_pkg::OFS_GRP_CTL0 + 8'(4 * g)) begin
               grp_ctl_r[g] <= reg_wdata;
            end
         end
         for (int c = 0; c < res_pkg::NUM_CNT; c++) begin
            if (reg_addr == res_pkg::OFS_CNT_CFG0 + 8'(4 * c)) begin
               cnt_cfg_r[c] <= reg_wdata & res_pkg::CFG_WMASK;
            end
         end
      end
   end

   // Register reads, data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata_r <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata_r <= 32'h0000_0000;
         for (int g = 0; g < res_pkg::NUM_GRP; g++) begin
            if (reg_addr == res_pkg::OFS_GRP_CTL0 + 8'(4 * g)) begin
               reg_rdata_r <= grp_ctl_r[g];
            end
         end
         for (int c = 0; c < res_pkg::NUM_CNT; c++) begin
            if (reg_addr == res_pkg::OFS_CNT_CFG0 + 8'(4 * c)) begin
               reg_rdata_r <= cnt_cfg_r[c];
            end
         end
         if (reg_addr == res_pkg::OFS_STATUS) begin
            reg_rdata_r <= {18'h0_0000, cnt_inc_r, 2'h0, cfg_valid};
         end
      end else begin
         reg_rdata_r <= 32'h0000_0000;
      end
   end
   assign reg_rdata = reg_rdata_r;

   // Divider for partial counting of clearing cycles
   always_ff @(posedge ref_clk) begin
      if (reset || !retire_in.clr_active) begin
         clr_div_r <= '0;
      end else if (clr_div_r == ($clog2(res_pkg::CLEAR_DIV))'(res_pkg::CLEAR_DIV - 1)) begin
         clr_div_r <= '0;
      end else begin
         clr_div_r <= clr_div_r + 1'b1;
      end
   end
   assign clr_phase = (clr_div_r == '0);

   // Event match for one counter given its group control and source
   function automatic logic evt_hit(input logic        hi_grp,
                                    input logic [31:0] ctl,
                                    input logic [2:0]  src,
                                    input res_pkg::res_retire_s ev,
                                    input logic        phase);
      logic [6:0]  es;
      logic [15:0] m;
      logic        h;
      es = ctl[res_pkg::ESEL_HI:res_pkg::ESEL_LO];
      m  = ctl[res_pkg::EMASK_HI:res_pkg::EMASK_LO];
      h  = 1'b0;
      if (!hi_grp) begin
         if (es == res_pkg::ESEL_MISPRED && src == res_pkg::SRC_MISPRED) begin
            h = ev.mispred_retire && m[res_pkg::NON_SPECULATIVE_QUAL]
                && !ev.bogus;
         end
      end else if (src == res_pkg::SRC_GRP23) begin
         if (es == res_pkg::ESEL_ASSIST) begin
            h = ev.fp_assist_retire_evt && |({m[res_pkg::INPUT_OPERAND_ASSIST_SEL],
                   m[res_pkg::RESULT_UNDERFLOW_ASSIST_SEL],
                   m[res_pkg::RESULT_OVERFLOW_ASSIST_SEL],
                   m[res_pkg::FP_STACK_OVERFLOW_SEL],
                   m[res_pkg::FP_STACK_UNDERFLOW_SEL]} & ev.assist_type);
         end else if (es == res_pkg::ESEL_CLEAR) begin
            h = (m[res_pkg::CLEAR_ANY_SEL] && ev.clr_active && phase)
                || (m[res_pkg::MEM_ORDER_FLUSH_SEL] && ev.clr_mem_order)
                || (m[res_pkg::SELF_MOD_CODE_FLUSH_SEL] && ev.clr_self_mod);
         end
      end
      return h;
   endfunction

   // Counters 12,13,16 use groups 0/2; 14,15,17 use groups 1/3
   for (genvar c = 0; c < res_pkg::NUM_CNT; c++) begin : g_cnt
      localparam logic ODD_SET = (c == 2) || (c == 3) || (c == 5);
      logic       hi_grp;
      logic [1:0] grp;
      logic [2:0] src;
      logic [6:0] es;
      assign hi_grp = cnt_cfg_r[c][res_pkg::CFG_GHI_BIT];
      assign grp    = {hi_grp, ODD_SET};
      assign src    = cnt_cfg_r[c][res_pkg::SRC_HI:res_pkg::SRC_LO];
      assign es     = grp_ctl_r[grp][res_pkg::ESEL_HI:res_pkg::ESEL_LO];
      assign cfg_valid[c] = cnt_cfg_r[c][res_pkg::CFG_EN_BIT]
         && ((!hi_grp && es == res_pkg::ESEL_MISPRED && src == res_pkg::SRC_MISPRED)
         || (hi_grp && src == res_pkg::SRC_GRP23
             && (es == res_pkg::ESEL_ASSIST || es == res_pkg::ESEL_CLEAR)));
      assign hit[c] = cfg_valid[c]
         && evt_hit(hi_grp, grp_ctl_r[grp], src, retire_in, clr_phase);
   end

   // Registered increment pulses
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_inc_r <= 6'h00;
      end else begin
         cnt_inc_r <= hit;
      end
   end
   assign cnt_inc = cnt_inc_r;

   // Sampling request bit is stored but never honoured
   assign precise_sampling_req = 1'b0;
endmodule
`default_nettype wire

// ===== sim/res_selector_asserts.sv
/* Port checker for res_selector, bound to every instance.
   Assumes one clock with a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module res_selector_chk (
   // Clock and reset
   input wire logic                 ref_clk,
   input wire logic                 reset,
   // Register port
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_addr,
   input wire logic [31:0]          reg_wdata,
   input wire logic [31:0]          reg_rdata,
   // Events and counters
   input wire res_pkg::res_retire_s retire_in,
   input wire logic [5:0]           cnt_inc,
   input wire logic                 precise_sampling_req
);
   logic ev_any;
   assign ev_any = |{retire_in.mispred_retire, retire_in.fp_assist_retire_evt, retire_in[2:0]};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence wr_rd_s(a);
      reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a;
   endsequence
   no_psamp_a: assert property (!precise_sampling_req) else $error("psamp set");
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not idle");
   unmap_rd_a: assert property (reg_rd && reg_addr > 8'h28 |=> reg_rdata == 32'h0) else $error("unmap");
   inc_cause_a: assert property (!ev_any |=> cnt_inc == 6'h0) else $error("no cause");
   bogus_blk_a: assert property (retire_in == 11'h600 |=> cnt_inc == 6'h0) else $error("bogus");
   no_type_a: assert property (retire_in == 11'h100 |=> cnt_inc == 6'h0) else $error("no type");
   cfg_rb_a: assert property (wr_rd_s(8'h10) |=> reg_rdata == ($past(reg_wdata, 3) & 32'hf003))
      else $error("cfg readback");
   grp_rb_a: assert property (wr_rd_s(8'h08) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("ctl readback");
endmodule
bind res_selector res_selector_chk res_selector_chk_i (.ref_clk, .reset, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .retire_in, .cnt_inc, .precise_sampling_req);
`default_nettype wire

// ===== sim/res_selector_tb.sv
/* Self-checking bench for res_selector.
   Drives the register port and retirement inputs directly. */
`timescale 1ns/1ps
`default_nettype none
module res_selector_tb;
   logic                 ref_clk = 1'b0;
   logic                 reset, reg_wr, reg_rd, precise_sampling_req;
   logic [7:0]           reg_addr;
   logic [31:0]          reg_wdata, reg_rdata, d;
   logic [5:0]           cnt_inc;
   res_pkg::res_retire_s retire_in;
   int                   error_cnt, n_tests, n;
   res_selector res_selector_i (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .retire_in, .cnt_inc, .precise_sampling_req);
   initial forever #10 ref_clk = ~ref_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) error_cnt++;
      if (got !== exp) $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      {reg_addr, reg_wdata} <= {a, v};
      {reg_wr, reg_rd} <= {w, !w};
      @(posedge ref_clk);
      {reg_wr, reg_rd} <= 2'b00;
      #1 d = reg_rdata;
      @(posedge ref_clk);
   endtask
   task automatic fire(input logic [10:0] v, input logic [5:0] e);
      retire_in <= v;
      @(posedge ref_clk);
      retire_in <= '0;
      #1 chk(32'(cnt_inc), 32'(e));
      @(posedge ref_clk);
   endtask
   task automatic t_regs;
      bus(1, 8'h10, 32'hffff_ffff);
      bus(0, 8'h10, 32'h0);
      chk(d, res_pkg::CFG_WMASK);
      chk(32'(precise_sampling_req), 32'h0);
      bus(0, 8'h40, 32'h0);
      chk(d, 32'h0);
   endtask
   task automatic t_mispred;
      bus(1, 8'h00, 32'h0600_0200);
      bus(1, 8'h04, 32'h0600_0200);
      bus(1, 8'h10, 32'h0000_9000);
      bus(1, 8'h24, 32'h0000_9000);
      bus(1, 8'h14, 32'h0000_9001);
      fire(11'h400, 6'h21);
      fire(11'h600, 6'h00);
      bus(1, 8'h00, 32'h0600_0000);
      fire(11'h400, 6'h20);
      bus(0, 8'h28, 32'h0);
      chk(d, 32'h0000_0021);
   endtask
   task automatic t_assist;
      bus(1, 8'h10, 32'h0000_b001);
      bus(1, 8'h14, 32'h0000_b000);
      for (int i = 0; i < 5; i++) begin
         bus(1, 8'h08, 32'h0600_0000 | (32'h200 << i));
         bus(0, 8'h08, 32'h0);
         chk(d, 32'h0600_0000 | (32'h200 << i));
         fire(11'h100 | (11'h008 << i), 6'h01);
         fire(11'h100 | (11'h008 << ((i + 1) % 5)), 6'h00);
      end
      fire(11'h100, 6'h00);
   endtask
   task automatic t_clear;
      bus(1, 8'h08, 32'h0400_0800);
      fire(11'h002, 6'h01);
      fire(11'h109, 6'h00);
      bus(1, 8'h08, 32'h0400_8000);
      fire(11'h001, 6'h01);
      fire(11'h002, 6'h00);
      bus(1, 8'h08, 32'h0400_0200);
      n = 0;
      retire_in <= 11'h004;
      repeat (4) begin
         @(posedge ref_clk);
         #1 n += cnt_inc[0];
      end
      @(posedge ref_clk);
      retire_in <= '0;
      chk(32'(n), 32'((4 + res_pkg::CLEAR_DIV - 1) / res_pkg::CLEAR_DIV));
   endtask
   task automatic t_map;
      bus(1, 8'h00, 32'h0600_0200);
      bus(1, 8'h04, 32'h0000_0000);
      for (int c = 0; c < 6; c++) begin
         bus(1, 8'h10 + 8'(4 * c), 32'h0000_9000);
      end
      fire(11'h400, 6'h13);
      bus(1, 8'h00, 32'h0000_0000);
      bus(1, 8'h04, 32'h0600_0200);
      fire(11'h400, 6'h2c);
      bus(1, 8'h08, 32'h0600_0400);
      bus(1, 8'h0c, 32'h0400_8000);
      for (int c = 0; c < 6; c++) begin
         bus(1, 8'h10 + 8'(4 * c), 32'h0000_b001);
      end
      fire(11'h110, 6'h13);
      fire(11'h001, 6'h2c);
      bus(1, 8'h10, 32'h0000_9001);
      bus(1, 8'h14, 32'h0000_a001);
      fire(11'h110, 6'h10);
   endtask
   task automatic t_reset;
      retire_in <= 11'h001;
      reset     <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      #1 chk(32'(cnt_inc), 32'h0);
      @(posedge ref_clk);
      fire(11'h001, 6'h00);
      bus(0, 8'h0c, 32'h0);
      chk(d, res_pkg::RST_VAL);
      bus(0, 8'h24, 32'h0);
      chk(d, res_pkg::RST_VAL);
   endtask
   task automatic print_verdict;
      $display("errors=%0d checks=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      {reset, reg_wr, reg_rd, reg_addr, reg_wdata, retire_in} = {3'b100, 51'h0};
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs();
      t_mispred();
      t_assist();
      t_clear();
      t_map();
      t_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
